// ==== design/curing_channel_io_control.sv ====
// curing channel i/o control: triggers, banks, emergency stop, outputs
// Operation
// - batch mode: only channel 1 trigger starts channels; others ignored.
// - batch start with ch1 ready starts every standby channel.
// - individual mode: each trigger starts its own channel.
// - bank inputs binary, bit 3 high; bank number is value plus one.
// - bank inputs used only when bank switching is enabled.
// - active emergency stop halts irradiation at once.
// - stay stopped until emergency input returns inactive.
// - ready output high while channel is in standby.
// - irradiating output high while any channel irradiates.
// - error output high while an error condition exists.
// - ready output follows readiness within 200 ms.
// - batch: ready returns only after all non-off channels end.
// - individual: ready returns when own irradiation ends.
// - channel set off never shows ready.
// - emergency active on short (default) or open, chosen by setting.
// - trigger valid after 40 ms switch or 120 ms contact hold.
// - batch: ch1 trigger while any irradiates stops all channels.
// - setting selects batch (default) or individual control.
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
`include "curing_io_regs.svh"

module curing_channel_io_control
	import curing_io_pkg::*;
#(
	parameter int CLK_PER_MS = `CLK_HZ / `MS_PER_S
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic start_stop_trigger_ch1_i,
	input wire logic start_stop_trigger_ch2_i,
	input wire logic start_stop_trigger_ch3_i,
	input wire logic start_stop_trigger_ch4_i,
	input wire logic bank_select_bit0_i,
	input wire logic bank_select_bit1_i,
	input wire logic bank_select_bit2_i,
	input wire logic bank_select_bit3_i,
	input wire logic emergency_stop_in_i,
	output logic [3:0] channel_ready_out_o,
	output logic irradiating_out_o,
	output logic error_out_o,
	output logic [4:0] bank_number_o
);

	localparam logic [16:0] MS_LAST = 17'(CLK_PER_MS - 1);

	ctrl_t ctrl_ff;
	status_t stat;
	io_state_t state_ff;
	io_state_t nxt_state;
	logic [3:0] trig_raw;
	logic [3:0] trig_pulse;
	logic [3:0] bank_s1_ff;
	logic [3:0] bank_s2_ff;
	logic est_s1_ff;
	logic est_s2_ff;
	logic est_act;
	logic [16:0] ms_cnt_ff;
	logic ms_tick_ff;
	logic [3:0] run_ff;
	logic [3:0] rdy_now;
	logic [`DUR_W-1:0] dur_ff [4];
	logic [`DUR_W-1:0] left_ff [4];
	logic wb_req;
	logic [2:0] dur_idx;

	assign trig_raw = {start_stop_trigger_ch4_i, start_stop_trigger_ch3_i,
		start_stop_trigger_ch2_i, start_stop_trigger_ch1_i};

	// ****************************************************************
	// input conditioning
	// ****************************************************************
	for (genvar g = 0; g < 4; g++)
	begin : g_trig
		trigger_filter #(.CLK_PER_MS(CLK_PER_MS)) u_filt (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.raw_i(trig_raw[g]),
			.contact_i(ctrl_ff.contact_in),
			.pulse_o(trig_pulse[g])
		);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bank_s1_ff <= 4'h0;
			bank_s2_ff <= 4'h0;
			est_s1_ff <= 1'b0;
			est_s2_ff <= 1'b0;
		end
		else
		begin
			bank_s1_ff <= {bank_select_bit3_i, bank_select_bit2_i,
				bank_select_bit1_i, bank_select_bit0_i};
			bank_s2_ff <= bank_s1_ff;
			est_s1_ff <= emergency_stop_in_i;
			est_s2_ff <= est_s1_ff;
		end
	end

	// input high means a short circuit across the stop terminals
	assign est_act = ctrl_ff.estop_open ? !est_s2_ff : est_s2_ff;

	// ****************************************************************
	// millisecond tick for irradiation durations
	// ****************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ms_cnt_ff <= 17'h00000;
			ms_tick_ff <= 1'b0;
		end
		else
		begin
			ms_tick_ff <= (ms_cnt_ff == MS_LAST);
			ms_cnt_ff <= (ms_cnt_ff == MS_LAST) ? 17'h00000 :
				ms_cnt_ff + 17'h00001;
		end
	end

	// ****************************************************************
	// emergency state
	// ****************************************************************
	always_comb
	begin
		case (state_ff)
			S_NORMAL: nxt_state = est_act ? S_ESTOP : S_NORMAL;
			S_ESTOP: nxt_state = est_act ? S_ESTOP : S_NORMAL;
			default: nxt_state = S_ESTOP;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_ff <= S_NORMAL;
		else
			state_ff <= nxt_state;
	end

	// ****************************************************************
	// channel readiness and irradiation
	// ****************************************************************
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			rdy_now[i] = !ctrl_ff.ch_off[i] && state_ff == S_NORMAL &&
				!est_act;
			if (ctrl_ff.individual_mode)
				rdy_now[i] = rdy_now[i] && !run_ff[i];
			else
				rdy_now[i] = rdy_now[i] && !(|run_ff);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			run_ff <= 4'h0;
			for (int i = 0; i < 4; i++)
				left_ff[i] <= '0;
		end
		else if (est_act || state_ff == S_ESTOP)
			run_ff <= 4'h0;
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				// a zero duration runs until a stop trigger
				if (ms_tick_ff && run_ff[i] && dur_ff[i] != '0)
				begin
					left_ff[i] <= left_ff[i] - `DUR_W'(1);
					if (left_ff[i] <= `DUR_W'(1))
						run_ff[i] <= 1'b0;
				end
				if (ctrl_ff.individual_mode && trig_pulse[i])
				begin
					if (rdy_now[i])
					begin
						run_ff[i] <= 1'b1;
						left_ff[i] <= dur_ff[i];
					end
					else
						run_ff[i] <= 1'b0;
				end
				if (!ctrl_ff.individual_mode && trig_pulse[0])
				begin
					if (|run_ff)
						run_ff[i] <= 1'b0;
					else if (rdy_now[0] && !ctrl_ff.ch_off[i])
					begin
						run_ff[i] <= 1'b1;
						left_ff[i] <= dur_ff[i];
					end
				end
				if (ctrl_ff.ch_off[i])
					run_ff[i] <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// terminal outputs
	// ****************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			channel_ready_out_o <= 4'h0;
			irradiating_out_o <= 1'b0;
			error_out_o <= 1'b0;
			bank_number_o <= 5'h01;
		end
		else
		begin
			channel_ready_out_o <= rdy_now;
			irradiating_out_o <= |run_ff;
			error_out_o <= est_act || ctrl_ff.error_force;
			if (ctrl_ff.bank_en)
				bank_number_o <= {1'b0, bank_s2_ff} + 5'h01;
		end
	end

	// ****************************************************************
	// wishbone slave
	// ****************************************************************
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign dur_idx = wb_adr_i[4:2] - 3'h4;
	assign stat = '{bank: bank_number_o, estop: state_ff == S_ESTOP,
		error: error_out_o, irradiating: irradiating_out_o, run: run_ff,
		ready: channel_ready_out_o};

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_ff <= `CTRL_RESET;
			for (int i = 0; i < 4; i++)
				dur_ff[i] <= '0;
		end
		else if (wb_req && wb_we_i)
		begin
			if (wb_adr_i == `CTRL_OFS)
			begin
				if (wb_sel_i[0])
				begin
					ctrl_ff.individual_mode <= wb_dat_i[`CTRL_INDIV_BIT];
					ctrl_ff.contact_in <= wb_dat_i[`CTRL_CONTACT_BIT];
					ctrl_ff.estop_open <= wb_dat_i[`CTRL_ESTOP_OPEN_BIT];
					ctrl_ff.bank_en <= wb_dat_i[`CTRL_BANK_EN_BIT];
					ctrl_ff.error_force <= wb_dat_i[`CTRL_ERR_FORCE_BIT];
				end
				if (wb_sel_i[1])
					ctrl_ff.ch_off <=
						wb_dat_i[`CTRL_CH_OFF_MSB:`CTRL_CH_OFF_LSB];
			end
			else if (wb_adr_i >= `DUR_BASE_OFS && wb_adr_i <= `DUR_LAST_OFS &&
				wb_adr_i[1:0] == 2'h0)
			begin
				if (wb_sel_i[0])
					dur_ff[dur_idx[1:0]][7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					dur_ff[dur_idx[1:0]][15:8] <= wb_dat_i[15:8];
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h00000000;
			if (wb_req && !wb_we_i)
			begin
				if (wb_adr_i == `CTRL_OFS)
					wb_dat_o <= {20'h00000, ctrl_ff.ch_off, 3'h0,
						ctrl_ff.error_force, ctrl_ff.bank_en,
						ctrl_ff.estop_open, ctrl_ff.contact_in,
						ctrl_ff.individual_mode};
				else if (wb_adr_i == `STATUS_OFS)
					wb_dat_o <= {11'h000, stat.bank, 5'h00, stat.estop,
						stat.error, stat.irradiating, stat.run, stat.ready};
				else if (wb_adr_i >= `DUR_BASE_OFS &&
					wb_adr_i <= `DUR_LAST_OFS && wb_adr_i[1:0] == 2'h0)
					wb_dat_o <= {16'h0000, dur_ff[dur_idx[1:0]]};
			end
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence batch_trig_s;
		!ctrl_ff.individual_mode && trig_pulse[0] && !est_act &&
			state_ff == S_NORMAL;
	endsequence

	chk_batch_only_ch1: assert property (!ctrl_ff.individual_mode &&
		!trig_pulse[0] |=> (run_ff & ~$past(run_ff)) == 4'h0)
		else $error("batch channel started without channel 1 trigger");
	chk_batch_start: assert property (batch_trig_s and
		(run_ff == 4'h0 && rdy_now[0]) |=> run_ff == ~$past(ctrl_ff.ch_off))
		else $error("batch start missed a standby channel");
	chk_batch_stop: assert property (batch_trig_s and (run_ff != 4'h0)
		|=> run_ff == 4'h0)
		else $error("batch stop left a channel running");
	chk_indiv_start: assert property (ctrl_ff.individual_mode &&
		(trig_pulse & rdy_now) != 4'h0 |=>
		(run_ff & $past(trig_pulse) & $past(rdy_now)) ==
		($past(trig_pulse) & $past(rdy_now)))
		else $error("individual start missed");
	chk_bank_decode: assert property (ctrl_ff.bank_en |=>
		bank_number_o == {1'b0, $past(bank_s2_ff)} + 5'h01)
		else $error("bank number wrong");
	chk_bank_ignored: assert property (!ctrl_ff.bank_en |=>
		$stable(bank_number_o))
		else $error("bank changed while disabled");
	chk_estop_halt: assert property (est_act |=> run_ff == 4'h0 &&
		state_ff == S_ESTOP ##1 !irradiating_out_o)
		else $error("emergency stop did not halt");
	chk_estop_hold: assert property (state_ff == S_ESTOP && est_act |=>
		state_ff == S_ESTOP && channel_ready_out_o == 4'h0)
		else $error("left emergency stop early");
	chk_ready_follow: assert property (rdy_now != channel_ready_out_o
		|=> channel_ready_out_o == $past(rdy_now))
		else $error("ready output lags");
	chk_off_not_ready: assert property (ctrl_ff.ch_off != 4'h0 |=>
		(channel_ready_out_o & $past(ctrl_ff.ch_off)) == 4'h0)
		else $error("off channel shows ready");
	chk_batch_ready: assert property (!ctrl_ff.individual_mode &&
		run_ff != 4'h0 |=> channel_ready_out_o == 4'h0)
		else $error("batch ready while irradiating");
	chk_uv_output: assert property (
		run_ff != 4'h0 |=> irradiating_out_o)
		else $error("irradiating output missing");
	chk_error_out: assert property (
		ctrl_ff.error_force |=> error_out_o)
		else $error("error output missing");

endmodule // curing_channel_io_control

// ==== common/curing_io_regs.svh ====
// register map, field positions, reset values and timing figures
`ifndef CURING_IO_REGS_SVH
`define CURING_IO_REGS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04
`define DUR_BASE_OFS 8'h10
`define DUR_LAST_OFS 8'h1c

// ****************************************************************
// control register fields
// ****************************************************************
`define CTRL_INDIV_BIT 0
`define CTRL_CONTACT_BIT 1
`define CTRL_ESTOP_OPEN_BIT 2
`define CTRL_BANK_EN_BIT 3
`define CTRL_ERR_FORCE_BIT 4
`define CTRL_CH_OFF_LSB 8
`define CTRL_CH_OFF_MSB 11
`define CTRL_RESET 9'h000

// ****************************************************************
// status register fields
// ****************************************************************
`define STAT_READY_LSB 0
`define STAT_RUN_LSB 4
`define STAT_IRR_BIT 8
`define STAT_ERR_BIT 9
`define STAT_ESTOP_BIT 10
`define STAT_BANK_LSB 16

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ 100000000
`define MS_PER_S 1000
`define HOLD_SWITCH_MS 40
`define HOLD_CONTACT_MS 120
`define READY_RESP_MS 200
`define DUR_W 16

`endif

// ==== common/curing_io_pkg.sv ====
// types shared by the curing channel i/o control block
package curing_io_pkg;

	typedef struct packed {
		logic [3:0] ch_off;
		logic error_force;
		logic bank_en;
		logic estop_open;
		logic contact_in;
		logic individual_mode;
	} ctrl_t;

	typedef struct packed {
		logic [4:0] bank;
		logic estop;
		logic error;
		logic irradiating;
		logic [3:0] run;
		logic [3:0] ready;
	} status_t;

	typedef enum logic [1:0] {
		S_NORMAL = 2'b01,
		S_ESTOP = 2'b10
	} io_state_t;

endpackage

// ==== design/trigger_filter.sv ====
// trigger input synchroniser, hold-time qualifier and one-shot
`timescale 1ns/10ps
`include "curing_io_regs.svh"

module trigger_filter
	import curing_io_pkg::*;
#(
	parameter int CLK_PER_MS = 100000
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic raw_i,
	input wire logic contact_i,
	output logic pulse_o
);

	localparam logic [23:0] LIM_S = 24'(`HOLD_SWITCH_MS * CLK_PER_MS);
	localparam logic [23:0] LIM_C = 24'(`HOLD_CONTACT_MS * CLK_PER_MS);

	logic sync1_ff;
	logic sync2_ff;
	logic [23:0] cnt_ff;
	logic fired_ff;
	logic [23:0] lim;

	assign lim = contact_i ? LIM_C : LIM_S;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= raw_i;
			sync2_ff <= sync1_ff;
		end
	end

	// one pulse once the level has stood for the full hold time
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_ff <= 24'h000000;
			fired_ff <= 1'b0;
			pulse_o <= 1'b0;
		end
		else
		begin
			pulse_o <= 1'b0;
			if (!sync2_ff)
			begin
				cnt_ff <= 24'h000000;
				fired_ff <= 1'b0;
			end
			else if (!fired_ff)
			begin
				if (cnt_ff == lim - 24'h000001)
				begin
					pulse_o <= 1'b1;
					fired_ff <= 1'b1;
				end
				else
					cnt_ff <= cnt_ff + 24'h000001;
			end
		end
	end

	chk_pulse_single: assert property (
		@(posedge clk_i) disable iff (rst_i) pulse_o |=> !pulse_o [*2])
		else $error("trigger pulse repeated");

	chk_hold_time: assert property (
		@(posedge clk_i) disable iff (rst_i) $rose(pulse_o) |->
		$past(sync2_ff) && $past(cnt_ff) == $past(lim) - 24'h000001)
		else $error("trigger pulse before hold time");

endmodule // trigger_filter

// ==== test/ext_controller.sv ====
// external controller model driving trigger, bank and emergency pins
`timescale 1ns/10ps

module ext_controller
(
	input wire logic clk_i,
	output logic [3:0] trig_o,
	output logic [3:0] bank_o,
	output logic estop_o
);
	initial
	begin
		trig_o = 4'h0;
		bank_o = 4'h0;
		estop_o = 1'b0;
	end

	// hold one trigger for a number of cycles, release, let it settle
	task automatic press(input int ch, input int cycles);
		@(posedge clk_i);
		trig_o[ch] <= 1'b1;
		repeat (cycles) @(posedge clk_i);
		trig_o[ch] <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask

	task automatic set_bank(input logic [3:0] v);
		@(posedge clk_i);
		bank_o <= v;
		repeat (5) @(posedge clk_i);
	endtask

	task automatic set_estop(input logic v);
		@(posedge clk_i);
		estop_o <= v;
		repeat (6) @(posedge clk_i);
	endtask
endmodule // ext_controller

// ==== test/tb_top.sv ====
// self-checking bench for the curing channel i/o control block
`timescale 1ns/10ps
`include "curing_io_regs.svh"

module tb_top;
	import curing_io_pkg::*;
	localparam int HOLD = 440;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [3:0] trig;
	logic [3:0] bank_pins;
	logic estop;
	logic [3:0] ready;
	logic irr;
	logic err;
	logic [4:0] bank;
	int failures = 0;
	int total_checks = 0;
	integer seed = 32'hb028c96a;
	logic [31:0] rd_q[$];
	logic [12:0] pin_q[$];
	logic [31:0] exp_rd;
	logic [12:0] exp_pin;
	logic chk_pins = 1'b0;
	logic [4:0] cur_bank = 5'h01;
	logic [3:0] v;

	always #5 clk_i = ~clk_i;

	curing_channel_io_control #(.CLK_PER_MS(10)) uut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.start_stop_trigger_ch1_i(trig[0]),
		.start_stop_trigger_ch2_i(trig[1]),
		.start_stop_trigger_ch3_i(trig[2]),
		.start_stop_trigger_ch4_i(trig[3]),
		.bank_select_bit0_i(bank_pins[0]),
		.bank_select_bit1_i(bank_pins[1]),
		.bank_select_bit2_i(bank_pins[2]),
		.bank_select_bit3_i(bank_pins[3]),
		.emergency_stop_in_i(estop),
		.channel_ready_out_o(ready),
		.irradiating_out_o(irr),
		.error_out_o(err),
		.bank_number_o(bank)
	);

	ext_controller ctl (
		.clk_i(clk_i),
		.trig_o(trig),
		.bank_o(bank_pins),
		.estop_o(estop)
	);

	// ****************************************************************
	// result watcher
	// ****************************************************************
	always @(posedge clk_i)
	begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
		begin
			exp_rd = rd_q.pop_front();
			total_checks++;
			if (wb_dat_o !== exp_rd)
			begin
				failures++;
				$display("MISMATCH wb_dat_o expected %h seen %h", exp_rd,
					wb_dat_o);
			end
		end
		if (chk_pins === 1'b1)
		begin
			exp_pin = pin_q.pop_front();
			total_checks++;
			if ({bank, err, irr, ready} !== exp_pin[10:0])
			begin
				failures++;
				$display("MISMATCH pins expected %h seen %h", exp_pin[10:0],
					{bank, err, irr, ready});
			end
		end
	end

	// ****************************************************************
	// drivers
	// ****************************************************************
	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] dat, input logic [3:0] sel = 4'hf);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		@(posedge clk_i iff wb_ack_o === 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		rd_q.push_back(exp);
		wb(1'b0, adr, 32'h0);
	endtask

	task automatic pins(input logic [3:0] rdy, input logic ir,
		input logic er);
		pin_q.push_back({2'b00, cur_bank, er, ir, rdy});
		@(posedge clk_i);
		chk_pins <= 1'b1;
		@(posedge clk_i);
		chk_pins <= 1'b0;
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (40000) @(posedge clk_i);
		failures++;
		report_and_stop();
	end

	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		pins(4'hf, 1'b0, 1'b0);
		rd(`CTRL_OFS, 32'h0);
		rd(8'h40, 32'h0);
		wb(1'b1, `CTRL_OFS, 32'h0000_0200);
		rd(`CTRL_OFS, 32'h0000_0200);
		pins(4'hd, 1'b0, 1'b0);
		$display("test reset_regs done");
		ctl.press(0, 900);
		pins(4'h0, 1'b1, 1'b0);
		ctl.press(1, HOLD);
		pins(4'h0, 1'b1, 1'b0);
		ctl.press(0, HOLD);
		pins(4'hd, 1'b0, 1'b0);
		ctl.press(0, 300);
		pins(4'hd, 1'b0, 1'b0);
		$display("test batch done");
		wb(1'b1, `CTRL_OFS, 32'h0000_0001);
		ctl.press(2, HOLD);
		pins(4'hb, 1'b1, 1'b0);
		ctl.press(3, HOLD);
		pins(4'h3, 1'b1, 1'b0);
		ctl.press(2, HOLD);
		pins(4'h7, 1'b1, 1'b0);
		ctl.press(3, HOLD);
		pins(4'hf, 1'b0, 1'b0);
		$display("test individual done");
		ctl.press(0, HOLD);
		pins(4'he, 1'b1, 1'b0);
		ctl.set_estop(1'b1);
		pins(4'h0, 1'b0, 1'b1);
		ctl.press(0, HOLD);
		pins(4'h0, 1'b0, 1'b1);
		ctl.set_estop(1'b0);
		pins(4'hf, 1'b0, 1'b0);
		ctl.set_estop(1'b1);
		wb(1'b1, `CTRL_OFS, 32'h0000_0004);
		repeat (4) @(posedge clk_i);
		pins(4'hf, 1'b0, 1'b0);
		ctl.set_estop(1'b0);
		pins(4'h0, 1'b0, 1'b1);
		$display("test emergency done");
		wb(1'b1, `CTRL_OFS, 32'h0000_0002);
		ctl.press(0, 500);
		pins(4'hf, 1'b0, 1'b0);
		ctl.press(0, 1300);
		pins(4'h0, 1'b1, 1'b0);
		ctl.press(0, 1300);
		pins(4'hf, 1'b0, 1'b0);
		$display("test contact done");
		ctl.set_bank(4'h9);
		pins(4'hf, 1'b0, 1'b0);
		wb(1'b1, `CTRL_OFS, 32'h0000_0008);
		for (int i = 0; i < 6; i++)
		begin
			v = (i == 0) ? 4'hf : 4'($random(seed));
			ctl.set_bank(v);
			cur_bank = {1'b0, v} + 5'h01;
			pins(4'hf, 1'b0, 1'b0);
		end
		wb(1'b1, `CTRL_OFS, 32'h0000_0000);
		ctl.set_bank(~v);
		pins(4'hf, 1'b0, 1'b0);
		rd(`STATUS_OFS, {11'h0, cur_bank, 8'h0, 4'h0, 4'hf});
		$display("test bank done");
		// only byte lane 0 enabled: upper duration byte must stay zero
		wb(1'b1, `DUR_BASE_OFS, 32'h0000_0302, 4'h1);
		rd(`DUR_BASE_OFS, 32'h0000_0002);
		ctl.press(0, HOLD);
		rd(`STATUS_OFS, {11'h0, cur_bank, 7'h0, 1'b1, 4'he, 4'h0});
		ctl.press(0, HOLD);
		pins(4'hf, 1'b0, 1'b0);
		wb(1'b1, `CTRL_OFS, 32'h0000_0010);
		pins(4'hf, 1'b0, 1'b1);
		wb(1'b1, `CTRL_OFS, 32'h0000_0000);
		$display("test duration done");
		report_and_stop();
	end
endmodule // tb_top
